/* File: rtl/tce_timer_capture.sv */
// Function
// - Run bit halts or advances counter
// - Prescale codes divide by 128 down to 1
// - Clock source picks fast oscillator, ignores prescale
// - Overflow sets sticky flag until software clears
// - High byte write latched, low commits both
// - Low byte read snapshots whole counter
// - Capture mode field, active only while running
// - Mode alone does not start measuring
// - Start edge, count, stop edge, clear go, flag
// - High pulse: rise starts, fall stops
// - Low pulse: fall starts, rise stops
// - Cycle: rise starts, next rise stops
// - Input select picks pin or oscillator
// - Event counter enable, only while running
// - First rise starts both; event overflow stops
// - Event high part latched, low commits all
// - Event low read snapshots all bits
// - Counter increments, overflows from all ones
// - Flag with enable raises interrupt request
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "tce_consts.svh"
module tce_timer_capture #(
	parameter int ADDR_W = 12,
	parameter int CNT_W  = 16,
	parameter int EVT_W  = 10
) (
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              fcpu_tick,
	input  wire logic              fhosc_tick,
	input  wire logic              measure_input_pin,
	input  wire logic              resistance_oscillator,
	output logic                   timer_irq
);
	localparam logic [CNT_W-1:0] CNT_ONES = '1;
	localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);
	localparam logic [EVT_W-1:0] EVT_ONES = '1;
	localparam logic [EVT_W-1:0] EVT_ONE  = EVT_W'(1);

	if (ADDR_W < 12 || ADDR_W > 32 || CNT_W < 9 || CNT_W > 16
		|| EVT_W < 9 || EVT_W > 16) begin : g_bad_param
		$error("tce_timer_capture: unsupported parameter value");
	end

	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [9:0] idx);
		hit = ((a >> 12) == '0) && (a[11:0] == {idx, 2'h0});
	endfunction

	function automatic logic mapped(input logic [ADDR_W-1:0] a);
		mapped = hit(a, `TCE_IDX_MODE) || hit(a, `TCE_IDX_CNT_LO) || hit(a, `TCE_IDX_CNT_HI)
			|| hit(a, `TCE_IDX_EVT_LO) || hit(a, `TCE_IDX_EVT_HI) || hit(a, `TCE_IDX_CAP)
			|| hit(a, `TCE_IDX_IRQ);
	endfunction

	tce_pkg::tce_mode_t      timer_mode_reg;
	tce_pkg::tce_cap_t       cap_ctrl_reg;
	tce_pkg::tce_cap_t       cap_ctrl_next;
	tce_pkg::tce_irq_t       irq_ctrl_reg;
	tce_pkg::tce_irq_t       irq_ctrl_next;
	tce_pkg::tce_cap_state_t cap_state_reg;
	tce_pkg::tce_cap_state_t cap_state_next;
	logic [CNT_W-1:0]        cnt_reg;
	logic [CNT_W-1:0]        cnt_next;
	logic [CNT_W-9:0]        cnt_hi_reg;
	logic [CNT_W-9:0]        cnt_hi_next;
	logic [EVT_W-1:0]        evt_reg;
	logic [EVT_W-1:0]        evt_next;
	logic [EVT_W-9:0]        evt_hi_reg;
	logic [EVT_W-9:0]        evt_hi_next;
	logic [6:0]              pre_reg;
	logic [6:0]              pre_next;
	logic [ADDR_W-1:0]       aw_addr_reg;
	logic [7:0]              w_data_reg;
	logic                    w_lane0_reg;
	logic                    irq_reg;

	// Bus handshakes
	wire logic aw_hs   = s_axi_awvalid & s_axi_awready;
	wire logic w_hs    = s_axi_wvalid & s_axi_wready;
	wire logic b_hs    = s_axi_bvalid & s_axi_bready;
	wire logic ar_hs   = s_axi_arvalid & s_axi_arready;
	wire logic r_hs    = s_axi_rvalid & s_axi_rready;
	wire logic wr_fire = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
	wire logic wr_ok   = wr_fire & w_lane0_reg;

	// Write and read decode
	wire logic wr_mode   = wr_ok & hit(aw_addr_reg, `TCE_IDX_MODE);
	wire logic wr_cnt_lo = wr_ok & hit(aw_addr_reg, `TCE_IDX_CNT_LO);
	wire logic wr_cnt_hi = wr_ok & hit(aw_addr_reg, `TCE_IDX_CNT_HI);
	wire logic wr_evt_lo = wr_ok & hit(aw_addr_reg, `TCE_IDX_EVT_LO);
	wire logic wr_evt_hi = wr_ok & hit(aw_addr_reg, `TCE_IDX_EVT_HI);
	wire logic wr_cap    = wr_ok & hit(aw_addr_reg, `TCE_IDX_CAP);
	wire logic wr_irq    = wr_ok & hit(aw_addr_reg, `TCE_IDX_IRQ);
	wire logic rd_cnt_lo = ar_hs & hit(s_axi_araddr, `TCE_IDX_CNT_LO);
	wire logic rd_evt_lo = ar_hs & hit(s_axi_araddr, `TCE_IDX_EVT_LO);

	wire logic [7:0] cnt_hi_ext = 8'(cnt_hi_reg);
	wire logic [7:0] evt_hi_ext = 8'(evt_hi_reg);
	wire logic [7:0] irq_ext    = 8'(irq_ctrl_reg);
	wire logic [7:0] rd_byte    =
		hit(s_axi_araddr, `TCE_IDX_MODE)   ? timer_mode_reg :
		hit(s_axi_araddr, `TCE_IDX_CNT_LO) ? cnt_reg[7:0] :
		hit(s_axi_araddr, `TCE_IDX_CNT_HI) ? cnt_hi_ext :
		hit(s_axi_araddr, `TCE_IDX_EVT_LO) ? evt_reg[7:0] :
		hit(s_axi_araddr, `TCE_IDX_EVT_HI) ? evt_hi_ext :
		hit(s_axi_araddr, `TCE_IDX_CAP)    ? cap_ctrl_reg :
		hit(s_axi_araddr, `TCE_IDX_IRQ)    ? irq_ext : 8'h00;

	// Timer clock: prescaled instruction ticks or raw oscillator ticks
	wire logic       run      = timer_mode_reg.run;
	wire logic [6:0] pre_mask = `TCE_PRE_FULL >> timer_mode_reg.prescale;
	wire logic       pre_hit  = fcpu_tick & ((pre_reg & pre_mask) == pre_mask);
	wire logic       tmr_tick = run & (timer_mode_reg.clk_src ? fhosc_tick : pre_hit);
	assign pre_next = !run ? `TCE_RST_PRE : fcpu_tick ? pre_reg + `TCE_PRE_ONE : pre_reg;

	// Measured input; a select change mid-level can fake an edge, so set it before go
	wire logic sig_raw = cap_ctrl_reg.input_sel ? resistance_oscillator : measure_input_pin;
	logic sig_level;
	logic sig_rise;
	logic sig_fall;
	tce_edge u_edge (
		.aclk    (aclk),
		.aresetn (aresetn),
		.din     (sig_raw),
		.level   (sig_level),
		.rise    (sig_rise),
		.fall    (sig_fall)
	);

	// Capture sequencing
	wire logic [1:0] cap_mode  = cap_ctrl_reg.mode;
	wire logic       cap_on    = run & (cap_mode != `TCE_CAP_OFF);
	wire logic       cap_event = run & cap_ctrl_reg.event_en;
	wire logic       evt_wrap  = evt_reg == EVT_ONES;
	wire logic       start_hit = (cap_event | cap_mode != `TCE_CAP_LOW) ? sig_rise : sig_fall;
	wire logic       stop_hit  = cap_event ? sig_rise & evt_wrap :
		(cap_mode == `TCE_CAP_HIGH) ? sig_fall : sig_rise;
	wire logic       measuring = cap_state_reg == tce_pkg::ST_MEAS;
	wire logic       cap_done  = measuring & cap_on & stop_hit;
	wire logic       cnt_run   = tmr_tick & (~cap_on | measuring);
	wire logic       cnt_ovf   = cnt_run & (cnt_reg == CNT_ONES) & ~wr_cnt_lo;
	// Gated by go so an aborted measurement does not bump the event count
	wire logic       evt_run   = measuring & cap_on & cap_ctrl_reg.go & cap_event & sig_rise;

	always_comb begin
		cap_state_next = cap_state_reg;
		case (cap_state_reg)
			tce_pkg::ST_IDLE: begin
				if (cap_on && cap_ctrl_reg.go) begin
					cap_state_next = tce_pkg::ST_ARM;
				end
			end
			tce_pkg::ST_ARM: begin
				if (!cap_on || !cap_ctrl_reg.go) begin
					cap_state_next = tce_pkg::ST_IDLE;
				end else if (start_hit) begin
					cap_state_next = tce_pkg::ST_MEAS;
				end
			end
			tce_pkg::ST_MEAS: begin
				if (!cap_on || !cap_ctrl_reg.go || stop_hit) begin
					cap_state_next = tce_pkg::ST_IDLE;
				end
			end
			default: cap_state_next = tce_pkg::ST_IDLE;
		endcase
	end

	always_comb begin
		cap_ctrl_next = cap_ctrl_reg;
		if (wr_cap) begin
			cap_ctrl_next     = w_data_reg;
			cap_ctrl_next.rsv = 3'h0;
		end else if (cap_done) begin
			cap_ctrl_next.go = 1'b0;
		end
	end

	// Flag set wins over a software clear in the same cycle
	always_comb begin
		irq_ctrl_next = irq_ctrl_reg;
		if (wr_irq) begin
			irq_ctrl_next.en = w_data_reg[`TCE_IRQ_EN_BIT];
			if (!w_data_reg[`TCE_IRQ_FLAG_BIT]) begin
				irq_ctrl_next.flag = 1'b0;
			end
		end
		if (cnt_ovf || cap_done) begin
			irq_ctrl_next.flag = 1'b1;
		end
	end

	// Counters; a bus write beats a count in the same cycle
	assign cnt_next = wr_cnt_lo ? {cnt_hi_reg, w_data_reg} :
		cnt_run ? cnt_reg + CNT_ONE : cnt_reg;
	assign cnt_hi_next = wr_cnt_hi ? w_data_reg[CNT_W-9:0] :
		rd_cnt_lo ? cnt_reg[CNT_W-1:8] : cnt_hi_reg;
	assign evt_next = wr_evt_lo ? {evt_hi_reg, w_data_reg} :
		evt_run ? evt_reg + EVT_ONE : evt_reg;
	assign evt_hi_next = wr_evt_hi ? w_data_reg[EVT_W-9:0] :
		rd_evt_lo ? evt_reg[EVT_W-1:8] : evt_hi_reg;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			timer_mode_reg <= `TCE_RST_BYTE;
			cap_ctrl_reg   <= `TCE_RST_BYTE;
			irq_ctrl_reg   <= 2'h0;
			cap_state_reg  <= tce_pkg::ST_IDLE;
			cnt_reg        <= '0;
			cnt_hi_reg     <= '0;
			evt_reg        <= '0;
			evt_hi_reg     <= '0;
			pre_reg        <= `TCE_RST_PRE;
			irq_reg        <= 1'b0;
		end else begin
			if (wr_mode) begin
				timer_mode_reg <= {w_data_reg[7:3], 3'h0};
			end
			cap_ctrl_reg  <= cap_ctrl_next;
			irq_ctrl_reg  <= irq_ctrl_next;
			cap_state_reg <= cap_state_next;
			cnt_reg       <= cnt_next;
			cnt_hi_reg    <= cnt_hi_next;
			evt_reg       <= evt_next;
			evt_hi_reg    <= evt_hi_next;
			pre_reg       <= pre_next;
			irq_reg       <= irq_ctrl_reg.flag & irq_ctrl_reg.en;
		end
	end
	assign timer_irq = irq_reg;

	// AXI4-Lite slave: one write and one read outstanding
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `TCE_RESP_OKAY;
			aw_addr_reg   <= '0;
			w_data_reg    <= `TCE_RST_BYTE;
			w_lane0_reg   <= 1'b0;
		end else begin
			if (aw_hs) begin
				aw_addr_reg   <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (w_hs) begin
				w_data_reg   <= s_axi_wdata[7:0];
				w_lane0_reg  <= s_axi_wstrb[`TCE_LANE0_BIT];
				s_axi_wready <= 1'b0;
			end
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= mapped(aw_addr_reg) ? `TCE_RESP_OKAY : `TCE_RESP_SLVERR;
			end
			if (b_hs) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h00000000;
			s_axi_rresp   <= `TCE_RESP_OKAY;
		end else if (ar_hs) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rdata   <= {24'h000000, rd_byte};
			s_axi_rresp   <= mapped(s_axi_araddr) ? `TCE_RESP_OKAY : `TCE_RESP_SLVERR;
		end else if (r_hs) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
		end
	end

	// Checks
	wire logic [CNT_W-9:0] cnt_top = cnt_reg[CNT_W-1:8];
	wire logic [EVT_W-9:0] evt_top = evt_reg[EVT_W-1:8];

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	property p_halt;
		!run && !wr_cnt_lo |=> cnt_reg == $past(cnt_reg);
	endproperty
	a_halt: assert property (p_halt) else $error("counter moved while halted");

	property p_div128;
		tmr_tick && !timer_mode_reg.clk_src && timer_mode_reg.prescale == 3'h0
			|-> pre_reg == `TCE_PRE_FULL && fcpu_tick;
	endproperty
	a_div128: assert property (p_div128) else $error("divide by 128 tick misplaced");

	property p_fast_src;
		run && timer_mode_reg.clk_src |-> tmr_tick == fhosc_tick;
	endproperty
	a_fast_src: assert property (p_fast_src) else $error("fast source tick wrong");

	property p_ovf_flag;
		cnt_ovf |=> irq_ctrl_reg.flag && cnt_reg == '0;
	endproperty
	a_ovf_flag: assert property (p_ovf_flag) else $error("overflow did not set flag");

	property p_flag_sticky;
		irq_ctrl_reg.flag && !(wr_irq && !w_data_reg[`TCE_IRQ_FLAG_BIT]) |=> irq_ctrl_reg.flag;
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped by itself");

	property p_wr_pair;
		wr_cnt_lo |=> cnt_reg == {$past(cnt_hi_reg), $past(w_data_reg)};
	endproperty
	a_wr_pair: assert property (p_wr_pair) else $error("counter pair write wrong");

	property p_rd_snap;
		rd_cnt_lo && !wr_cnt_hi |=> cnt_hi_reg == $past(cnt_top)
			&& s_axi_rdata[7:0] == $past(cnt_reg[7:0]);
	endproperty
	a_rd_snap: assert property (p_rd_snap) else $error("counter snapshot wrong");

	property p_evt_snap;
		rd_evt_lo && !wr_evt_hi |=> evt_hi_reg == $past(evt_top);
	endproperty
	a_evt_snap: assert property (p_evt_snap) else $error("event snapshot wrong");

	property p_cap_off;
		!cap_on |=> cap_state_reg == tce_pkg::ST_IDLE;
	endproperty
	a_cap_off: assert property (p_cap_off) else $error("capture active while off");

	property p_no_go;
		cap_state_reg == tce_pkg::ST_IDLE && !cap_ctrl_reg.go |=> cap_state_reg == tce_pkg::ST_IDLE;
	endproperty
	a_no_go: assert property (p_no_go) else $error("capture armed without go");

	property p_done;
		cap_done && !wr_cap |=> cap_state_reg == tce_pkg::ST_IDLE && !cap_ctrl_reg.go
			&& irq_ctrl_reg.flag;
	endproperty
	a_done: assert property (p_done) else $error("capture end not handled");

	property p_high_wait;
		cap_state_reg == tce_pkg::ST_ARM && cap_on && cap_ctrl_reg.go && !cap_event
			&& cap_mode == `TCE_CAP_HIGH && !sig_rise |=> cap_state_reg != tce_pkg::ST_MEAS;
	endproperty
	a_high_wait: assert property (p_high_wait) else $error("high pulse started off rise");

	property p_low_start;
		cap_state_reg == tce_pkg::ST_ARM && cap_on && cap_ctrl_reg.go && !cap_event
			&& cap_mode == `TCE_CAP_LOW && sig_fall |=> cap_state_reg == tce_pkg::ST_MEAS;
	endproperty
	a_low_start: assert property (p_low_start) else $error("low pulse missed fall");

	property p_cycle_hold;
		measuring && cap_on && cap_ctrl_reg.go && !cap_event && cap_mode == `TCE_CAP_CYCLE
			&& !sig_rise |=> measuring;
	endproperty
	a_cycle_hold: assert property (p_cycle_hold) else $error("cycle stopped early");

	property p_evt_step;
		evt_run && !evt_wrap && !wr_evt_lo |=> evt_reg == $past(evt_reg) + EVT_ONE && measuring;
	endproperty
	a_evt_step: assert property (p_evt_step) else $error("event count step wrong");

	property p_irq_out;
		irq_ctrl_reg.flag && irq_ctrl_reg.en |=> timer_irq;
	endproperty
	a_irq_out: assert property (p_irq_out) else $error("interrupt not requested");

	property p_cov_high;
		cap_done && cap_mode == `TCE_CAP_HIGH && !cap_event;
	endproperty
	c_cov_high: cover property (p_cov_high);

	property p_cov_cycle;
		cap_done && cap_mode == `TCE_CAP_CYCLE;
	endproperty
	c_cov_cycle: cover property (p_cov_cycle);

	property p_cov_event;
		cap_done && cap_event;
	endproperty
	c_cov_event: cover property (p_cov_event);

	property p_cov_ovf;
		cnt_ovf ##2 timer_irq;
	endproperty
	c_cov_ovf: cover property (p_cov_ovf);
endmodule // tce_timer_capture
`default_nettype wire

/* File: inc/tce_consts.svh */
`ifndef TCE_CONSTS_SVH
`define TCE_CONSTS_SVH

// Register indices; byte address is four times the index
`define TCE_IDX_MODE      10'h0A0
`define TCE_IDX_CNT_LO    10'h0A1
`define TCE_IDX_CNT_HI    10'h0A2
`define TCE_IDX_EVT_LO    10'h0A3
`define TCE_IDX_EVT_HI    10'h0A4
`define TCE_IDX_CAP       10'h0A5
`define TCE_IDX_IRQ       10'h0A8

// Reset values
`define TCE_RST_BYTE      8'h00
`define TCE_RST_PRE       7'h00

// Field positions
`define TCE_IRQ_FLAG_BIT  0
`define TCE_IRQ_EN_BIT    1
`define TCE_LANE0_BIT     0

// Prescaler
`define TCE_PRE_FULL      7'h7F
`define TCE_PRE_ONE       7'h01

// Capture mode encodings
`define TCE_CAP_OFF       2'h0
`define TCE_CAP_HIGH      2'h1
`define TCE_CAP_LOW       2'h2
`define TCE_CAP_CYCLE     2'h3

// AXI responses
`define TCE_RESP_OKAY     2'h0
`define TCE_RESP_SLVERR   2'h2

`endif

/* File: inc/tce_pkg.sv */
package tce_pkg;

	typedef struct packed {
		logic       run;
		logic [2:0] prescale;
		logic       clk_src;
		logic [2:0] rsv;
	} tce_mode_t;

	typedef struct packed {
		logic       event_en;
		logic [2:0] rsv;
		logic       input_sel;
		logic       go;
		logic [1:0] mode;
	} tce_cap_t;

	typedef struct packed {
		logic en;
		logic flag;
	} tce_irq_t;

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_ARM,
		ST_MEAS
	} tce_cap_state_t;

endpackage

/* File: rtl/tce_edge.sv */
`timescale 1ns/1ps
`default_nettype none
module tce_edge (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic din,
	output logic      level,
	output logic      rise,
	output logic      fall
);
	logic meta_reg;
	logic sync_reg;
	logic last_reg;

	// Only the second and third stages are looked at; the first may be metastable
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
			last_reg <= 1'b0;
		end else begin
			meta_reg <= din;
			sync_reg <= meta_reg;
			last_reg <= sync_reg;
		end
	end

	assign level = sync_reg;
	assign rise  = sync_reg & ~last_reg;
	assign fall  = ~sync_reg & last_reg;
endmodule // tce_edge
`default_nettype wire

/* File: dv/tce_pulse_src.sv */
`timescale 1ns/1ps
`default_nettype none
module tce_pulse_src (
	input  wire logic       aclk,
	input  wire logic [7:0] high_len,
	input  wire logic [7:0] low_len,
	output logic            sig
);
	logic [7:0] cnt_reg;
	initial begin
		sig = 1'b0;
		cnt_reg = 8'h00;
	end
	// Free-running square wave; a new length is compared every cycle, so it applies to the phase in progress
	always @(posedge aclk) begin
		if (cnt_reg >= (sig ? high_len : low_len) - 8'h01) begin
			cnt_reg <= 8'h00;
			sig <= ~sig;
		end else begin
			cnt_reg <= cnt_reg + 8'h01;
		end
	end
endmodule // tce_pulse_src
`default_nettype wire

/* File: dv/t1_timer_capture_event_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "tce_consts.svh"
module t1_timer_capture_event_tb;
	logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic        awready, wready, bvalid, arready, rvalid, irq, fcpu, fhosc, pin, osc, s;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [1:0]  bresp, rresp, m;
	logic [7:0]  ph, pl, oh, ol, d, d2;
	logic [15:0] r;
	logic [3:0]  strb;
	integer      seed = 32'h221DB4D3;
	int          errors, tests_run, cyc, e;

	tce_timer_capture #(.ADDR_W(12), .CNT_W(16), .EVT_W(10)) i_tce_timer_capture (
		.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(strb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.fcpu_tick(fcpu), .fhosc_tick(fhosc), .measure_input_pin(pin),
		.resistance_oscillator(osc), .timer_irq(irq)
	);
	tce_pulse_src i_pin_src (.aclk(aclk), .high_len(ph), .low_len(pl), .sig(pin));
	tce_pulse_src i_osc_src (.aclk(aclk), .high_len(oh), .low_len(ol), .sig(osc));

	initial begin
		aclk = 1'b0;
		forever #2 aclk = ~aclk;
	end

	task automatic final_report;
		$display("comparisons %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// Cycle ceiling well above the longest expected run
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 30000) begin
			errors++;
			final_report;
		end
	end

	task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic wr(input logic [9:0] idx, input logic [7:0] v, input logic [1:0] er = 2'h0);
		logic aw_ok, w_ok;
		@(posedge aclk);
		awaddr <= {idx, 2'b00};
		wdata <= {24'h000000, v};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		while (!(aw_ok && w_ok)) begin
			@(posedge aclk);
			if (!aw_ok && awready === 1'b1) begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_ok && wready === 1'b1) begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do @(posedge aclk); while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk("bresp", {30'h0, er}, {30'h0, bresp});
	endtask

	task automatic rd(input logic [9:0] idx, output logic [7:0] v, input logic [1:0] er = 2'h0);
		@(posedge aclk);
		araddr <= {idx, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		rready <= 1'b0;
		v = rdata[7:0];
		chk("rresp", {30'h0, er}, {30'h0, rresp});
		chk("rdata_upper", 32'h0, {8'h00, rdata[31:8]});
	endtask

	// Low byte first so the high byte holds the same snapshot
	task automatic rd16(output logic [15:0] v);
		logic [7:0] lo, hi;
		rd(`TCE_IDX_CNT_LO, lo);
		rd(`TCE_IDX_CNT_HI, hi);
		v = {hi, lo};
	endtask

	task automatic ld16(input logic [15:0] v);
		wr(`TCE_IDX_CNT_HI, v[15:8]);
		wr(`TCE_IDX_CNT_LO, v[7:0]);
	endtask

	task automatic pulses(input int k, input logic fc, input logic fh);
		repeat (k) begin
			@(posedge aclk);
			fcpu <= fc;
			fhosc <= fh;
			@(posedge aclk);
			fcpu <= 1'b0;
			fhosc <= 1'b0;
		end
	endtask

	task automatic wait_irq;
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 3000) begin
			@(posedge aclk);
			n++;
		end
		chk("timer_irq", 32'h1, {31'h0, irq});
	endtask

	function automatic logic near(input logic [15:0] got, input int exp);
		return (int'(got) + 1 >= exp) && (int'(got) <= exp + 1);
	endfunction

	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, fcpu, fhosc} = 8'h00;
		awaddr = 12'h000;
		araddr = 12'h000;
		wdata = 32'h0;
		strb = 4'hF;
		{ph, pl, oh, ol} = 32'h08080808;
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 9; i++) begin
			rd(`TCE_IDX_MODE + 10'(i), d, (i == 6 || i == 7) ? 2'h2 : 2'h0);
			chk("reset_value", 32'h0, {24'h0, d});
		end
		wr(10'h0A6, 8'h55, 2'h2);
		ld16(16'($random(seed)));
		e = {$random(seed)} % 65536;
		ld16(16'(e));
		wr(`TCE_IDX_CNT_HI, ~8'(e >> 8));
		rd16(r);
		chk("counter_pair", 32'(e), 32'(r));
		strb <= 4'hE;
		wr(`TCE_IDX_CNT_HI, ~8'(e >> 8));
		strb <= 4'hF;
		rd(`TCE_IDX_CNT_HI, d);
		chk("strobe_off", 32'(8'(e >> 8)), {24'h0, d});
		e = {$random(seed)} % 1024;
		wr(`TCE_IDX_EVT_HI, {6'h00, 2'(e >> 8)});
		wr(`TCE_IDX_EVT_LO, 8'(e));
		wr(`TCE_IDX_EVT_HI, 8'h00);
		rd(`TCE_IDX_EVT_LO, d);
		rd(`TCE_IDX_EVT_HI, d2);
		chk("event_pair", 32'(e), {16'h0, d2, d});
		for (int i = 0; i < 9; i++) begin
			wr(`TCE_IDX_MODE, i == 8 ? 8'h08 : {1'b0, 3'(i), 4'h0});
			ld16(16'h0000);
			wr(`TCE_IDX_MODE, i == 8 ? 8'h88 : {1'b1, 3'(i), 4'h0});
			pulses(128, 1'b1, i == 8);
			wr(`TCE_IDX_MODE, 8'h00);
			pulses(8, 1'b1, 1'b1);
			rd16(r);
			chk("tick_count", i == 8 ? 32'd128 : 32'd1 << i, 32'(r));
		end
		wr(`TCE_IDX_IRQ, 8'h02);
		wr(`TCE_IDX_MODE, 8'h70);
		ld16(16'hFFFE);
		wr(`TCE_IDX_MODE, 8'hF0);
		pulses(1, 1'b1, 1'b0);
		repeat (4) @(posedge aclk);
		chk("irq_early", 32'h0, {31'h0, irq});
		pulses(1, 1'b1, 1'b0);
		repeat (4) @(posedge aclk);
		chk("irq_overflow", 32'h1, {31'h0, irq});
		wr(`TCE_IDX_MODE, 8'h70);
		rd16(r);
		chk("wrapped", 32'h0, 32'(r));
		rd(`TCE_IDX_IRQ, d);
		chk("flag_sticky", 32'h3, {24'h0, d});
		wr(`TCE_IDX_IRQ, 8'h02);
		repeat (3) @(posedge aclk);
		chk("irq_cleared", 32'h0, {31'h0, irq});
		fcpu <= 1'b1;
		for (int c = 1; c <= 4; c++) begin
			ph <= 8'(4 + {$random(seed)} % 60);
			pl <= 8'(4 + {$random(seed)} % 60);
			oh <= 8'(4 + {$random(seed)} % 60);
			ol <= 8'(4 + {$random(seed)} % 60);
			m = (c == 4) ? 2'h1 : 2'(c);
			s = (c == 4);
			wr(`TCE_IDX_MODE, 8'h70);
			ld16(16'h0000);
			wr(`TCE_IDX_IRQ, 8'h02);
			wr(`TCE_IDX_CAP, {4'h0, s, 1'b0, m});
			e = s ? oh : (m == 2'h1 ? ph : (m == 2'h2 ? pl : ph + pl));
			wr(`TCE_IDX_MODE, 8'hF0);
			repeat (200) @(posedge aclk);
			rd16(r);
			chk("mode_without_go", 32'h0, 32'(r));
			wr(`TCE_IDX_CAP, {4'h0, s, 1'b1, m});
			wait_irq;
			rd(`TCE_IDX_CAP, d);
			chk("go_cleared", {28'h0, s, 1'b0, m}, {24'h0, d});
			rd16(r);
			chk("width", 32'h1, {31'h0, near(r, e)});
		end
		wr(`TCE_IDX_MODE, 8'h70);
		ld16(16'h0000);
		wr(`TCE_IDX_EVT_HI, 8'h03);
		wr(`TCE_IDX_EVT_LO, 8'hFC);
		wr(`TCE_IDX_IRQ, 8'h02);
		wr(`TCE_IDX_CAP, 8'h81);
		wr(`TCE_IDX_MODE, 8'hF0);
		wr(`TCE_IDX_CAP, 8'h85);
		wait_irq;
		rd16(r);
		chk("event_span", 32'h1, {31'h0, near(r, 4 * (ph + pl))});
		rd(`TCE_IDX_EVT_LO, d);
		rd(`TCE_IDX_EVT_HI, d2);
		chk("event_wrap", 32'h0, {16'h0, d2, d});
		final_report;
	end
endmodule // t1_timer_capture_event_tb
`default_nettype wire
